// ### rtl/emd_defs.vh
// Purpose: constants for the emulation memory map decoder
// Assumes: 24-bit processor address, top byte is the bank
// Notes: definitions only
`ifndef EMD_DEFS_VH
`define EMD_DEFS_VH
// processor mode codes (one-hot free, plain encoding on the mode port)
`define EMD_MODE_SINGLE 3'h0
`define EMD_MODE_MEX8 3'h1
`define EMD_MODE_MEX16 3'h2
`define EMD_MODE_MPU8 3'h3
`define EMD_MODE_MPU16 3'h4
// area map codes
`define EMD_MAP_NOUSE 2'h0
`define EMD_MAP_INT 2'h1
`define EMD_MAP_EXT 2'h2
// fixed windows, as bank bytes
`define EMD_FLASH_BANK_LO 8'hf8
`define EMD_FLASH_BANK_HI 8'hff
// area sizes in 64 KB banks
`define EMD_LEN256_BANKS 9'h004
`define EMD_LEN1M_BANKS 9'h010
// pin synchroniser reset: hold and wait idle high, boot pin low
`define EMD_PIN_RST 3'h6
// emulation memory budget in 64 KB banks: 4 MB and 3.25 MB
`define EMD_BUDGET_FULL 9'h040
`define EMD_BUDGET_MEX 9'h034
// routing codes on the select output
`define EMD_SEL_CPU 3'h0
`define EMD_SEL_MON 3'h1
`define EMD_SEL_FLASH 3'h2
`define EMD_SEL_EXPINT 3'h3
`define EMD_SEL_EXTSET 3'h4
`define EMD_SEL_EXTDEF 3'h5
`define EMD_SEL_VECT 3'h6
`endif

// ### rtl/emd_decoder.v
// Purpose: route each processor access to pod memory, cpu internals or target board
// Assumes: configuration is stable before the program runs; address from same clock
// Notes: one-cycle registered decision per access strobe
`timescale 1ns/100ps
`default_nettype none
`include "emd_defs.vh"

// Notes on behaviour
// RULE1 - 64 KB monitor bank at configured top byte
// RULE2 - reject monitor bank hitting internal or vectors
// RULE3 - debugger cannot see or change monitor contents
// RULE4 - five processor mode selections supported
// RULE5 - single-chip or expansion: boot pin low
// RULE6 - microprocessor mode: boot pin high
// RULE7 - target holds wait and hold inactive high
// RULE8 - no target board: skip pin checks
// RULE9 - flash window F80000h-FFFFFFh except microprocessor
// RULE10 - expansion areas off in single-chip, four otherwise
// RULE11 - area base is bank then sixteen zeros
// RULE12 - 256 KB banks multiples of 04
// RULE13 - 1 MB banks multiples of 10
// RULE14 - area spans base to base plus length
// RULE15 - internal area served by emulation memory
// RULE16 - external or unused area goes to target
// RULE17 - uncovered address defaults to external
// RULE18 - explicit external downloads faster than default
// RULE19 - total length within 4 MB, 3.25 MB expansion
// RULE20 - overlapping areas are rejected
// RULE21 - reset vector area always from pod memory
// RULE22 - special function and RAM always internal
// RULE23 - fixed priority cpu, monitor, flash, areas, external
module emd_decoder #(
    parameter NAREA = 4,
    parameter [7:0] INT_BANK_LO = 8'h00,
    parameter [7:0] INT_BANK_HI = 8'h00,
    parameter [7:0] RSV_BANK_LO = 8'h01,
    parameter [7:0] RSV_BANK_HI = 8'h01,
    parameter [7:0] VECT_BANK = 8'hff,
    parameter [15:0] VECT_OFS_LO = 16'hffdc
) (
    input wire ref_clk,
    input wire rstn,
    input wire [2:0] proc_mode,
    input wire [7:0] monitor_bank,
    input wire [NAREA*8-1:0] area_bank,
    input wire [NAREA-1:0] area_len_1m,
    input wire [NAREA*2-1:0] area_map,
    input wire target_present,
    input wire boot_mode_pin,
    input wire wait_req_n,
    input wire hold_req_n,
    input wire acc_valid,
    input wire [23:0] acc_addr,
    input wire acc_debugger,
    output reg cfg_ok_r,
    output reg cfg_err_mon_r,
    output reg cfg_err_area_r,
    output reg cfg_err_pins_r,
    output reg pins_stall_r,
    output reg sel_valid_r,
    output reg [2:0] sel_code_r,
    output reg [1:0] sel_area_r,
    output reg dbg_block_r,
    output reg fast_dl_r
);

    // ************************************************************
    // reset release and pin synchronisers
    // ************************************************************
    reg rst_s1_r;
    reg rst_s2_r;
    reg [2:0] pin_s1_r;
    reg [2:0] pin_s2_r;
    wire srst_n;

    // two-stage reset release
    // assertion is immediate, release waits two edges
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign srst_n = rst_s2_r;

    // board pins come from outside, two flops each
    // reset to the idle levels so a fresh reset never shows a stall
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            pin_s1_r <= `EMD_PIN_RST;
            pin_s2_r <= `EMD_PIN_RST;
        end else begin
            pin_s1_r <= {hold_req_n, wait_req_n, boot_mode_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    // ************************************************************
    // decode helpers
    // ************************************************************
    // number of 64 KB banks in one area
    function [8:0] area_banks;
        input len_1m;
        begin
            area_banks = len_1m ? `EMD_LEN1M_BANKS : `EMD_LEN256_BANKS;
        end
    endfunction

    // does bank b fall inside the area that starts at base
    function area_hit;
        input [7:0] base;
        input len_1m;
        input [7:0] b;
        reg [8:0] top;
        begin
            top = {1'b0, base} + area_banks(len_1m);
            area_hit = ({1'b0, b} >= {1'b0, base}) && ({1'b0, b} < top); // [RULE11] [RULE14]
        end
    endfunction

    // is bank b inside the fixed range lo to hi
    function bank_in;
        input [7:0] b;
        input [7:0] lo;
        input [7:0] hi;
        begin
            bank_in = (b >= lo) && (b <= hi);
        end
    endfunction

    // mode decode from the plain mode code
    wire mode_mpu = (proc_mode == `EMD_MODE_MPU8) || (proc_mode == `EMD_MODE_MPU16);
    wire mode_mex = (proc_mode == `EMD_MODE_MEX8) || (proc_mode == `EMD_MODE_MEX16);
    wire mode_sc = (proc_mode == `EMD_MODE_SINGLE);
    wire mode_legal = mode_sc || mode_mex || mode_mpu; // [RULE4]
    wire exp_on = mode_mex || mode_mpu; // [RULE10]

    // ************************************************************
    // configuration checks
    // ************************************************************
    wire [NAREA-1:0] area_used;
    wire [NAREA-1:0] area_align_bad;
    wire [NAREA-1:0] area_int;
    genvar gi;
    generate
        for (gi = 0; gi < NAREA; gi = gi + 1) begin : g_area
            wire [7:0] bk = area_bank[gi*8 +: 8];
            assign area_used[gi] = area_map[gi*2 +: 2] != `EMD_MAP_NOUSE;
            assign area_int[gi] = area_map[gi*2 +: 2] == `EMD_MAP_INT;
            // alignment of the bank to the area length
            assign area_align_bad[gi] = area_used[gi] &&
                (area_len_1m[gi] ? (bk[3:0] != 4'h0) : (bk[1:0] != 2'h0)); // [RULE12] [RULE13]
        end
    endgenerate

    // overlap over all used areas, budget over the used internal areas only
    reg ovl_bad;
    reg [8:0] total_banks;
    integer i;
    integer j;
    always @* begin
        ovl_bad = 1'b0;
        total_banks = 9'h000;
        for (i = 0; i < NAREA; i = i + 1) begin
            if (area_used[i] && area_int[i]) begin
                total_banks = total_banks + area_banks(area_len_1m[i]); // [RULE19]
            end
            for (j = i + 1; j < NAREA; j = j + 1) begin
                if (area_used[i] && area_used[j] &&
                    (area_hit(area_bank[i*8 +: 8], area_len_1m[i], area_bank[j*8 +: 8]) ||
                     area_hit(area_bank[j*8 +: 8], area_len_1m[j], area_bank[i*8 +: 8]))) begin
                    ovl_bad = 1'b1; // [RULE20]
                end
            end
        end
    end

    // internal areas draw on the emulation memory, external ones do not
    wire [8:0] budget = mode_mex ? `EMD_BUDGET_MEX : `EMD_BUDGET_FULL;
    wire budget_bad = total_banks > budget; // [RULE19]
    // area faults only matter while the areas are in use
    wire area_bad = exp_on && ((|area_align_bad) || ovl_bad || budget_bad); // [RULE19]

    // monitor bank may not sit on internals, reserved areas, internal rom or vectors
    wire mon_in_int = bank_in(monitor_bank, INT_BANK_LO, INT_BANK_HI);
    wire mon_in_rsv = bank_in(monitor_bank, RSV_BANK_LO, RSV_BANK_HI);
    wire mon_in_vect = (monitor_bank == VECT_BANK);
    // internal rom sits under the flash window only outside microprocessor mode
    wire mon_in_rom = !mode_mpu &&
                      bank_in(monitor_bank, `EMD_FLASH_BANK_LO, `EMD_FLASH_BANK_HI);
    wire mon_bad = mon_in_int || mon_in_rsv || mon_in_rom || mon_in_vect; // [RULE2]

    // pin levels checked only with a board attached
    wire boot_ok = mode_mpu ? pin_s2_r[0] : !pin_s2_r[0]; // [RULE5] [RULE6]
    wire pins_bad = target_present && !boot_ok; // [RULE8]
    // a low wait or hold request freezes the processor on the target bus
    wire stall = target_present && exp_on && !(pin_s2_r[1] && pin_s2_r[2]); // [RULE7]
    // an undefined mode code never counts as a good setup
    wire cfg_ok_nxt = mode_legal && !mon_bad && !area_bad && !pins_bad; // [RULE4]

    // registered configuration status
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            cfg_ok_r <= 1'b0;
            cfg_err_mon_r <= 1'b0;
            cfg_err_area_r <= 1'b0;
        end else begin
            cfg_ok_r <= cfg_ok_nxt;
            cfg_err_mon_r <= mon_bad;
            cfg_err_area_r <= area_bad;
        end
    end

    // registered pin status, three edges behind the pins themselves
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            cfg_err_pins_r <= 1'b0;
            pins_stall_r <= 1'b0;
        end else begin
            cfg_err_pins_r <= pins_bad;
            pins_stall_r <= stall;
        end
    end

    // ************************************************************
    // access routing
    // ************************************************************
    wire [7:0] ab = acc_addr[23:16];
    reg [2:0] code_nxt;
    reg [1:0] area_nxt;
    reg hit_found;
    integer k;

    // fixed regions, each decoded once from the access bank, the vector window also from the low 16 address bits
    wire hit_cpu = bank_in(ab, INT_BANK_LO, INT_BANK_HI); // [RULE22]
    wire hit_vect = (ab == VECT_BANK) && (acc_addr[15:0] >= VECT_OFS_LO); // [RULE21]
    wire hit_mon = (ab == monitor_bank); // [RULE1]
    wire hit_flash = !mode_mpu &&
                     bank_in(ab, `EMD_FLASH_BANK_LO, `EMD_FLASH_BANK_HI); // [RULE9]

    // areas first, lowest index last so it wins; fixed regions then override
    always @* begin
        code_nxt = `EMD_SEL_EXTDEF; // [RULE17]
        area_nxt = 2'h0;
        hit_found = 1'b0;
        if (exp_on) begin
            for (k = NAREA - 1; k >= 0; k = k - 1) begin
                if (area_used[k] && area_hit(area_bank[k*8 +: 8], area_len_1m[k], ab)) begin
                    hit_found = 1'b1;
                    area_nxt = k[1:0];
                    if (area_int[k]) begin
                        code_nxt = `EMD_SEL_EXPINT; // [RULE15]
                    end else begin
                        code_nxt = `EMD_SEL_EXTSET; // [RULE16]
                    end
                end
            end
        end
        // priority: cpu internals, vectors, monitor, flash, then the area result
        if (hit_cpu) begin
            code_nxt = `EMD_SEL_CPU; // [RULE22] [RULE23]
        end else if (hit_vect) begin
            code_nxt = `EMD_SEL_VECT; // [RULE21]
        end else if (hit_mon) begin
            code_nxt = `EMD_SEL_MON; // [RULE1] [RULE23]
        end else if (hit_flash) begin
            code_nxt = `EMD_SEL_FLASH; // [RULE9]
        end
    end

    // the answer strobe follows each access strobe by exactly one edge
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            sel_valid_r <= 1'b0;
        end else begin
            sel_valid_r <= acc_valid;
        end
    end

    // route and debugger flags hold until the next access
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            sel_code_r <= `EMD_SEL_EXTDEF;
            sel_area_r <= 2'h0;
            dbg_block_r <= 1'b0;
            fast_dl_r <= 1'b0;
        end else if (acc_valid) begin
            sel_code_r <= code_nxt;
            sel_area_r <= area_nxt;
            // debugger never reaches the real monitor contents
            dbg_block_r <= acc_debugger && (code_nxt == `EMD_SEL_MON); // [RULE3]
            // explicitly external areas take the fast download path
            fast_dl_r <= acc_debugger && hit_found &&
                         (code_nxt == `EMD_SEL_EXTSET); // [RULE18]
        end
    end

endmodule // emd_decoder
`default_nettype wire

// ### testbench/emd_decoder_chk.sv
// Purpose: port checker for the emulation memory map decoder
// Assumes: configuration held steady around each access
// Notes: bound to emd_decoder below
`timescale 1ns/100ps
`default_nettype none
module emd_decoder_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [2:0] proc_mode,
    input wire logic [7:0] monitor_bank,
    input wire logic acc_valid,
    input wire logic [23:0] acc_addr,
    input wire logic acc_debugger,
    input wire logic cfg_ok_r,
    input wire logic cfg_err_mon_r,
    input wire logic sel_valid_r,
    input wire logic [2:0] sel_code_r,
    input wire logic dbg_block_r,
    input wire logic fast_dl_r
);
    // ****
    // settle count hides the reset synchroniser
    // ****
    logic [2:0] up_r;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) up_r <= 3'h0;
        else if (up_r != 3'h7) up_r <= up_r + 3'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn || up_r != 3'h7);
    // routing of each access, one cycle later
    property p_cpu;
        acc_valid && acc_addr[23:16] == 8'h00 |=> sel_valid_r && sel_code_r == 3'h0;
    endproperty
    a_cpu: assert property (p_cpu) else $error("internal access not kept inside");
    property p_vec;
        acc_valid && acc_addr[23:16] == 8'hff && acc_addr[15:0] >= 16'hffdc
        |=> sel_code_r == 3'h6;
    endproperty
    a_vec: assert property (p_vec) else $error("vector not from pod");
    property p_mon;
        acc_valid && acc_addr[23:16] == monitor_bank && !cfg_err_mon_r
        |=> sel_code_r == 3'h1;
    endproperty
    a_mon: assert property (p_mon) else $error("monitor bank missed");
    property p_fla; acc_valid && acc_addr[23:19] == 5'h1f && acc_addr[23:16] != 8'hff
        && acc_addr[23:16] != monitor_bank && proc_mode < 3'h3 |=> sel_code_r == 3'h2; endproperty
    a_fla: assert property (p_fla) else $error("flash window missed");
    property p_mpu;
        acc_valid && (proc_mode == 3'h3 || proc_mode == 3'h4) |=> sel_code_r != 3'h2;
    endproperty
    a_mpu: assert property (p_mpu) else $error("flash used in mpu mode");
    property p_sgl;
        acc_valid && proc_mode == 3'h0 |=> sel_code_r != 3'h3 && sel_code_r != 3'h4;
    endproperty
    a_sgl: assert property (p_sgl) else $error("area used in single-chip");
    property p_dbg;
        sel_valid_r |-> dbg_block_r == ($past(acc_debugger) && sel_code_r == 3'h1);
    endproperty
    a_dbg: assert property (p_dbg) else $error("monitor block wrong");
    property p_fdl;
        sel_valid_r |-> fast_dl_r == ($past(acc_debugger) && sel_code_r == 3'h4);
    endproperty
    a_fdl: assert property (p_fdl) else $error("fast download wrong");
    // configuration status, one cycle lag
    property p_merr;
        monitor_bank == 8'h00 || monitor_bank == 8'hff |=> cfg_err_mon_r && !cfg_ok_r;
    endproperty
    a_merr: assert property (p_merr) else $error("bad monitor bank taken");
    property p_mode; proc_mode > 3'h4 |=> !cfg_ok_r; endproperty
    a_mode: assert property (p_mode) else $error("illegal mode taken");
    c_mon: cover property (sel_valid_r && sel_code_r == 3'h1);
    c_int: cover property (sel_valid_r && sel_code_r == 3'h3);
    c_ext: cover property (sel_valid_r && fast_dl_r);
endmodule // emd_decoder_chk
bind emd_decoder emd_decoder_chk i_emd_decoder_chk (.ref_clk(ref_clk), .rstn(rstn),
    .proc_mode(proc_mode), .monitor_bank(monitor_bank), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_debugger(acc_debugger), .cfg_ok_r(cfg_ok_r),
    .cfg_err_mon_r(cfg_err_mon_r), .sel_valid_r(sel_valid_r), .sel_code_r(sel_code_r),
    .dbg_block_r(dbg_block_r), .fast_dl_r(fast_dl_r));
`default_nettype wire

// ### testbench/emd_target_board.sv
// Purpose: target board pin model
// Assumes: board follows the selected mode unless told to misbehave
// Notes: pull-up pins idle high
`timescale 1ns/100ps
`default_nettype none
module emd_target_board (
    input wire logic ref_clk,
    input wire logic [2:0] mode,
    input wire logic bad_boot,
    input wire logic stall,
    output logic boot_mode_pin,
    output logic wait_req_n,
    output logic hold_req_n
);
    // pins change just after the edge
    always_ff @(posedge ref_clk) begin
        // the two microprocessor codes raise the boot pin, inverted while bad_boot is set
        boot_mode_pin <= ((mode == 3'h3) || (mode == 3'h4)) ^ bad_boot;
        wait_req_n <= !stall;
        hold_req_n <= !stall;
    end
endmodule // emd_target_board
`default_nettype wire

// ### testbench/test_emulation_memory_map_decoder.sv
// Purpose: self-checking bench for the memory map decoder
// Assumes: configuration changes only between accesses
// Notes: pins come from the board model
`timescale 1ns/100ps
`default_nettype none
module test_emulation_memory_map_decoder;
    logic ref_clk = 1'b0, rstn = 1'b0, acc_valid = 1'b0, acc_debugger = 1'b0;
    logic target_present = 1'b1, bad_boot = 1'b0, stall = 1'b0;
    logic [2:0] proc_mode = 3'h4;
    logic [7:0] monitor_bank = 8'hf0;
    logic [31:0] area_bank = 32'h00c0_8040;
    logic [3:0] area_len_1m = 4'h2;
    logic [7:0] area_map = 8'h09;
    logic [23:0] acc_addr = 24'h0;
    logic [7:0] bad_mon [4] = '{8'h00, 8'h01, 8'hff, 8'hf8};
    wire boot_mode_pin, wait_req_n, hold_req_n, cfg_ok_r, cfg_err_mon_r, cfg_err_area_r;
    wire cfg_err_pins_r, pins_stall_r, sel_valid_r, dbg_block_r, fast_dl_r;
    wire [2:0] sel_code_r;
    wire [1:0] sel_area_r;
    int mismatches = 0, num_checks = 0, cyc = 0;
    // ****
    // clock, timeout and the design
    // ****
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            print_verdict();
        end
    end
    emd_target_board i_emd_target_board (.ref_clk(ref_clk), .mode(proc_mode),
        .bad_boot(bad_boot), .stall(stall), .boot_mode_pin(boot_mode_pin),
        .wait_req_n(wait_req_n), .hold_req_n(hold_req_n));
    emd_decoder i_emd_decoder (.ref_clk(ref_clk), .rstn(rstn), .proc_mode(proc_mode),
        .monitor_bank(monitor_bank), .area_bank(area_bank), .area_len_1m(area_len_1m),
        .area_map(area_map), .target_present(target_present), .boot_mode_pin(boot_mode_pin),
        .wait_req_n(wait_req_n), .hold_req_n(hold_req_n), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .acc_debugger(acc_debugger), .cfg_ok_r(cfg_ok_r),
        .cfg_err_mon_r(cfg_err_mon_r), .cfg_err_area_r(cfg_err_area_r),
        .cfg_err_pins_r(cfg_err_pins_r), .pins_stall_r(pins_stall_r),
        .sel_valid_r(sel_valid_r), .sel_code_r(sel_code_r), .sel_area_r(sel_area_r),
        .dbg_block_r(dbg_block_r), .fast_dl_r(fast_dl_r));
    // compare and count
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one access from a rising edge; code 7 means any target route
    task automatic acc(input logic [23:0] a, input logic d, input logic [2:0] code);
        acc_valid <= 1'b1;
        acc_addr <= a;
        acc_debugger <= d;
        @(posedge ref_clk);
        acc_valid <= 1'b0;
        @(negedge ref_clk);
        chk({23'h0, sel_valid_r}, 24'h1);
        if (code != 3'h7) chk({21'h0, sel_code_r}, {21'h0, code});
        else chk({22'h0, sel_code_r[2:1]}, 24'h2);
        @(posedge ref_clk);
    endtask
    // let status follow the config, then compare ok/mon/area/pins
    task automatic st(input logic [3:0] e);
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({20'h0, cfg_ok_r, cfg_err_mon_r, cfg_err_area_r, cfg_err_pins_r}, {20'h0, e});
        @(posedge ref_clk);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        st(4'h8);
        acc(24'h400000, 1'b0, 3'h3);
        acc(24'h43ffff, 1'b0, 3'h3);
        acc(24'h440000, 1'b0, 3'h5);
        acc(24'h8fffff, 1'b1, 3'h4);
        chk({22'h0, sel_area_r}, 24'h1);
        chk({23'h0, fast_dl_r}, 24'h1);
        acc(24'h900000, 1'b1, 3'h5);
        chk({23'h0, fast_dl_r}, 24'h0);
        acc(24'hc00000, 1'b0, 3'h7);
        acc(24'hf0ffff, 1'b1, 3'h1);
        chk({23'h0, dbg_block_r}, 24'h1);
        acc(24'hf90000, 1'b0, 3'h5);
        acc(24'h001000, 1'b0, 3'h0);
        acc(24'hfffffe, 1'b0, 3'h6);
        monitor_bank <= 8'h40;
        st(4'h8);
        acc(24'h400000, 1'b0, 3'h1);
        monitor_bank <= 8'hf0;
        $display("test routing done");
        for (int m = 0; m < 6; m++) begin
            proc_mode <= 3'(m);
            st({m < 5, 1'b0, 1'b0, 1'b0});
        end
        proc_mode <= 3'h0;
        st(4'h8);
        acc(24'hf90000, 1'b0, 3'h2);
        acc(24'h400000, 1'b0, 3'h5);
        proc_mode <= 3'h1;
        st(4'h8);
        acc(24'hf80000, 1'b0, 3'h2);
        acc(24'h400000, 1'b0, 3'h3);
        $display("test modes done");
        bad_boot <= 1'b1;
        st(4'h1);
        proc_mode <= 3'h4;
        st(4'h1);
        target_present <= 1'b0;
        st(4'h8);
        target_present <= 1'b1;
        bad_boot <= 1'b0;
        stall <= 1'b1;
        st(4'h8);
        chk({23'h0, pins_stall_r}, 24'h1);
        stall <= 1'b0;
        $display("test pins done");
        area_bank <= 32'h00c0_8042;
        st(4'h2);
        area_bank <= 32'h00c0_8044;
        area_len_1m <= 4'h3;
        st(4'h2);
        area_bank <= 32'h00c0_4440;
        area_len_1m <= 4'h1;
        st(4'h2);
        area_bank <= 32'h5040_3020;
        area_len_1m <= 4'hf;
        area_map <= 8'h55;
        st(4'h8);
        proc_mode <= 3'h1;
        st(4'h2);
        foreach (bad_mon[i]) begin
            monitor_bank <= bad_mon[i];
            st(4'h6);
        end
        $display("test config done");
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({17'h0, cfg_ok_r, sel_valid_r, sel_code_r, dbg_block_r, fast_dl_r}, 24'h14);
        @(posedge ref_clk);
        rstn <= 1'b1;
        st(4'h6);
        $display("test reset done");
        print_verdict();
    end
endmodule // test_emulation_memory_map_decoder
`default_nettype wire
